// >>> common/sfh_pkg.sv
// What this block does
// - pause starts on pause-pin fall while selected and serial clock low.
// - pause ends on pause-pin rise while serial clock low.
// - pause freezes the transfer; bit counting resumes where it stopped.
// - while paused, output floats and serial clock and input are ignored.
// - deselect during pause abandons the sequence unless paused on a byte boundary past the opcode, then it executes; back to standby.
// - status write refused when guard pin low and lock bit set.
// - lock bit is bit 7; lock blocks level, select and lock changes.
// - bit 0 is busy, 1 during program or erase, 0 at power-up, read-only.
// - bit 1 shows the write-enable latch, read-only, 0 at power-up.
// - no program or erase accepted while the latch is 0.
// - latch cleared at power-up and after disable, program, erase, status write.
// - level bits 2-4, select and lock are read/write and nonvolatile.
// - select bit 5 at 1 protects the bottom, at 0 the top.
// - bit 6 is spare, reads 0, not writable.
// - select 0, levels 001/010/011 protect top eighth, quarter, half.
// - select 1, levels 001/010/011 protect bottom eighth, quarter, half.
// - levels 000 protect nothing; level msb 1 protects everything.
// - program or erase inside the protected region is rejected.
// - whole-array erase runs only with all level bits 0.
`default_nettype none
package sfh_pkg;
    localparam logic [7:0] SFH_OP_STATUS_WRITE = 8'h01;
    localparam logic [7:0] SFH_OP_PROG = 8'h02;
    localparam logic [7:0] SFH_OP_WR_DISABLE = 8'h04;
    localparam logic [7:0] SFH_OP_RDSR = 8'h05;
    localparam logic [7:0] SFH_OP_WR_ENABLE = 8'h06;
    localparam logic [7:0] SFH_OP_SE_A = 8'h20;
    localparam logic [7:0] SFH_OP_SE_B = 8'hd7;
    localparam logic [7:0] SFH_OP_BE = 8'hd8;
    localparam logic [7:0] SFH_OP_CE_A = 8'h60;
    localparam logic [7:0] SFH_OP_CE_B = 8'hc7;

    localparam int SFH_BIT_BUSY = 0;
    localparam int SFH_BIT_WR_LATCH = 1;
    localparam int SFH_BIT_LVL_LSB = 2;
    localparam int SFH_BIT_LVL_MID = 3;
    localparam int SFH_BIT_LVL_MSB = 4;
    localparam int SFH_BIT_SEL = 5;
    localparam int SFH_BIT_SPARE = 6;
    localparam int SFH_BIT_LOCK = 7;

    localparam logic SFH_BUSY_RESET = 1'b0;
    localparam logic SFH_WEL_RESET = 1'b0;
    localparam logic [4:0] SFH_NV_RESET = 5'h00;

    localparam int SFH_ADDR_W = 19;
    localparam int unsigned SFH_BUSY_CYCLES_DEFAULT = 1000;
    localparam logic [2:0] SFH_ADDR_BYTES = 3'h3;
    localparam logic [2:0] SFH_PROG_MIN_BYTES = 3'h4;

    typedef struct packed {
        logic csN;
        logic sck;
        logic si;
        logic holdN;
        logic wpN;
    } sfh_pins_t;

    localparam sfh_pins_t SFH_PINS_IDLE =
        '{csN: 1'b1, sck: 1'b0, si: 1'b0, holdN: 1'b1, wpN: 1'b1};

    typedef struct packed {
        logic lock;
        logic sel;
        logic lvlMsb;
        logic lvlMid;
        logic lvlLsb;
    } sfh_nv_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_OPC = 4'b0010,
        ST_BODY = 4'b0100,
        ST_SKIP = 4'b1000
    } sfh_state_t;
endpackage
`default_nettype wire

// >>> logic/sfh_sync.sv
`timescale 1ns/10ps
`default_nettype none
module sfh_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            meta_q <= RST_VAL;
            dout <= RST_VAL;
        end
        else
        begin
            meta_q <= din;
            dout <= meta_q;
        end
    end
endmodule // sfh_sync
`default_nettype wire

// >>> logic/sfh_top.sv
`timescale 1ns/10ps
`default_nettype none
module sfh_top import sfh_pkg::*; #(
    parameter int unsigned BUSY_CYCLES = SFH_BUSY_CYCLES_DEFAULT,
    parameter int ADDR_W = SFH_ADDR_W
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic csN,
    input wire logic sck,
    input wire logic si,
    input wire logic holdN,
    input wire logic wpN,
    output logic so,
    output logic soOe,
    output logic busy,
    output logic wrLatch,
    output logic opStart,
    output logic opReject
);
    sfh_pins_t pinsRaw;
    sfh_pins_t pinsS;
    logic sckP_q;
    logic holdP_q;
    logic csP_q;
    logic paused_q;
    sfh_state_t state_q;
    logic [2:0] bitCnt_q;
    logic [2:0] byteCnt_q;
    logic [7:0] shift_q;
    logic [7:0] cmd_q;
    logic [23:0] addr_q;
    logic [7:0] wrData_q;
    sfh_nv_t nv_q;
    logic [31:0] busyCnt_q;

    logic sckRise;
    logic sckFall;
    logic holdRise;
    logic holdFall;
    logic csRise;
    logic csFall;
    logic active;
    logic [7:0] shiftD;
    logic [7:0] statusByte;
    logic wholeBytes;
    logic isErase;
    logic doWrEnable;
    logic doWrDisable;
    logic doStatus;
    logic doStart;
    logic doReject;
    logic busyDone;
    logic inRead;

    // protected-region decode, also used for erase gating
    function automatic logic isProtected(input logic [ADDR_W-1:0] a, input sfh_nv_t p);
        logic [2:0] top3;
        top3 = a[ADDR_W-1 -: 3];
        if (p.lvlMsb)
            isProtected = 1'b1;
        else if ({p.lvlMid, p.lvlLsb} == 2'b00)
            isProtected = 1'b0;
        else if ({p.lvlMid, p.lvlLsb} == 2'b01)
            isProtected = p.sel ? (top3 == 3'h0) : (top3 == 3'h7);
        else if ({p.lvlMid, p.lvlLsb} == 2'b10)
            isProtected = p.sel ? (top3[2:1] == 2'h0) : (top3[2:1] == 2'h3);
        else
            isProtected = p.sel ? !top3[2] : top3[2];
    endfunction

    function automatic logic isOp(input logic [7:0] c, input logic [7:0] a, input logic [7:0] b);
        isOp = (c == a) || (c == b);
    endfunction

    assign pinsRaw = '{csN: csN, sck: sck, si: si, holdN: holdN, wpN: wpN};

    // all pins come from the host's domain
    // syncs start at idle pin levels, so no false edge follows reset
    sfh_sync #(
        .W($bits(sfh_pins_t)),
        .RST_VAL(SFH_PINS_IDLE)
    ) u_sync (
        .clock(clock),
        .rst(rst),
        .din(pinsRaw),
        .dout(pinsS)
    );

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            sckP_q <= 1'b0;
            holdP_q <= 1'b1;
            csP_q <= 1'b1;
        end
        else
        begin
            sckP_q <= pinsS.sck;
            holdP_q <= pinsS.holdN;
            csP_q <= pinsS.csN;
        end
    end

    assign sckRise = pinsS.sck && !sckP_q;
    assign sckFall = !pinsS.sck && sckP_q;
    assign holdRise = pinsS.holdN && !holdP_q;
    assign holdFall = !pinsS.holdN && holdP_q;
    assign csRise = pinsS.csN && !csP_q;
    assign csFall = !pinsS.csN && csP_q;
    // paused clock edges are dropped, so the counters just stand still
    assign active = !pinsS.csN && !paused_q;

    // pause pin is only honoured with the serial clock low
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            paused_q <= 1'b0;
        else if (pinsS.csN)
            paused_q <= 1'b0;
        else if (!paused_q && holdFall && !pinsS.sck)
            paused_q <= 1'b1;
        else if (paused_q && holdRise && !pinsS.sck)
            paused_q <= 1'b0;
    end

    assign shiftD = {shift_q[6:0], pinsS.si};

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            state_q <= ST_IDLE;
            bitCnt_q <= 3'h0;
            byteCnt_q <= 3'h0;
            shift_q <= 8'h00;
            cmd_q <= 8'h00;
        end
        else if (pinsS.csN)
        begin
            state_q <= ST_IDLE;
            bitCnt_q <= 3'h0;
            byteCnt_q <= 3'h0;
        end
        else if (csFall)
        begin
            state_q <= ST_OPC;
            bitCnt_q <= 3'h0;
            byteCnt_q <= 3'h0;
        end
        else if (sckRise && active)
        begin
            shift_q <= shiftD;
            bitCnt_q <= bitCnt_q + 3'h1;
            if (bitCnt_q == 3'h7)
            begin
                case (state_q)
                    ST_OPC:
                    begin
                        cmd_q <= shiftD;
                        // only status polling is served during an operation
                        if (busy && shiftD != SFH_OP_RDSR)
                            state_q <= ST_SKIP;
                        else
                            state_q <= ST_BODY;
                    end
                    ST_BODY:
                    begin
                        if (byteCnt_q != 3'h7)
                            byteCnt_q <= byteCnt_q + 3'h1;
                    end
                    default:
                        state_q <= state_q;
                endcase
            end
        end
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            addr_q <= 24'h000000;
            wrData_q <= 8'h00;
        end
        else if (sckRise && active && state_q == ST_BODY && bitCnt_q == 3'h7)
        begin
            if (byteCnt_q < SFH_ADDR_BYTES)
                addr_q <= {addr_q[15:0], shiftD};
            if (byteCnt_q == 3'h0)
                wrData_q <= shiftD;
        end
    end

    // execution happens at deselect and only on whole bytes
    assign wholeBytes = csRise && state_q == ST_BODY && bitCnt_q == 3'h0;
    assign isErase = isOp(cmd_q, SFH_OP_SE_A, SFH_OP_SE_B) || cmd_q == SFH_OP_BE;

    always_comb
    begin
        doWrEnable = 1'b0;
        doWrDisable = 1'b0;
        doStatus = 1'b0;
        doStart = 1'b0;
        doReject = 1'b0;
        if (wholeBytes)
        begin
            if (cmd_q == SFH_OP_WR_ENABLE && byteCnt_q == 3'h0)
                doWrEnable = 1'b1;
            else if (cmd_q == SFH_OP_WR_DISABLE && byteCnt_q == 3'h0)
                doWrDisable = 1'b1;
            // status write also wants the latch, like program and erase
            else if (cmd_q == SFH_OP_STATUS_WRITE && byteCnt_q == 3'h1)
            begin
                if ((!pinsS.wpN && nv_q.lock) || !wrLatch)
                    doReject = 1'b1;
                else
                begin
                    doStatus = 1'b1;
                    doStart = 1'b1;
                end
            end
            else if ((cmd_q == SFH_OP_PROG && byteCnt_q >= SFH_PROG_MIN_BYTES)
                || (isErase && byteCnt_q == SFH_ADDR_BYTES))
            begin
                if (!wrLatch || isProtected(addr_q[ADDR_W-1:0], nv_q))
                    doReject = 1'b1;
                else
                    doStart = 1'b1;
            end
            else if (isOp(cmd_q, SFH_OP_CE_A, SFH_OP_CE_B) && byteCnt_q == 3'h0)
            begin
                if (!wrLatch || {nv_q.lvlMsb, nv_q.lvlMid, nv_q.lvlLsb} != 3'h0)
                    doReject = 1'b1;
                else
                    doStart = 1'b1;
            end
        end
    end

    // levels, select and lock are not cleared by reset in silicon;
    // here the reset value stands in for the stored cells
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            nv_q <= SFH_NV_RESET;
        else if (doStatus)
        begin
            nv_q.lock <= wrData_q[SFH_BIT_LOCK];
            nv_q.sel <= wrData_q[SFH_BIT_SEL];
            nv_q.lvlMsb <= wrData_q[SFH_BIT_LVL_MSB];
            nv_q.lvlMid <= wrData_q[SFH_BIT_LVL_MID];
            nv_q.lvlLsb <= wrData_q[SFH_BIT_LVL_LSB];
        end
    end

    // one busy length for every operation; real times differ per command
    assign busyDone = busy && busyCnt_q == 32'h1;

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            busy <= SFH_BUSY_RESET;
            busyCnt_q <= 32'h0;
        end
        else if (doStart)
        begin
            busy <= 1'b1;
            busyCnt_q <= BUSY_CYCLES;
        end
        else if (busy)
        begin
            busyCnt_q <= busyCnt_q - 32'h1;
            if (busyDone)
                busy <= 1'b0;
        end
    end

    // latch drops on write disable or when the internal operation ends
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            wrLatch <= SFH_WEL_RESET;
        else if (doWrEnable)
            wrLatch <= 1'b1;
        else if (doWrDisable || busyDone)
            wrLatch <= 1'b0;
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            opStart <= 1'b0;
            opReject <= 1'b0;
        end
        else
        begin
            opStart <= doStart;
            opReject <= doReject;
        end
    end

    always_comb
    begin
        statusByte = 8'h00;
        statusByte[SFH_BIT_BUSY] = busy;
        statusByte[SFH_BIT_WR_LATCH] = wrLatch;
        statusByte[SFH_BIT_LVL_LSB] = nv_q.lvlLsb;
        statusByte[SFH_BIT_LVL_MID] = nv_q.lvlMid;
        statusByte[SFH_BIT_LVL_MSB] = nv_q.lvlMsb;
        statusByte[SFH_BIT_SEL] = nv_q.sel;
        statusByte[SFH_BIT_SPARE] = 1'b0;
        statusByte[SFH_BIT_LOCK] = nv_q.lock;
    end

    assign inRead = state_q == ST_BODY && cmd_q == SFH_OP_RDSR;

    // status read repeats every byte with the live busy bit
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            so <= 1'b0;
            soOe <= 1'b0;
        end
        else
        begin
            soOe <= active && inRead;
            if (sckFall && active && inRead)
                so <= statusByte[3'h7 - bitCnt_q];
        end
    end
endmodule // sfh_top
`default_nettype wire

// >>> tb/sfh_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module sfh_monitor #(
    parameter int BUSY_CYCLES = 20
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic csN,
    input wire logic sck,
    input wire logic si,
    input wire logic holdN,
    input wire logic wpN,
    input wire logic so,
    input wire logic soOe,
    input wire logic busy,
    input wire logic wrLatch,
    input wire logic opStart,
    input wire logic opReject
);
    int lenQ;
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            lenQ <= 0;
        else
            lenQ <= busy ? lenQ + 1 : 0;
    end
    default clocking @(posedge clock);
    endclocking
    default disable iff (rst);
    // pins seen raw; six cycles leave room for the input syncs
    sequence holdIn;
        $fell(holdN) && !csN && !sck;
    endsequence
    sequence holdOn;
        !holdN [*6];
    endsequence
    chk_hold_float: assert property (holdIn ##1 holdOn |-> !soOe)
        else $error("so driven in pause");
    chk_pause_so_frozen: assert property (holdIn ##1 holdOn |-> $stable(so))
        else $error("so moved in pause");
    chk_idle_float: assert property (csN [*6] |-> !soOe)
        else $error("so driven deselected");
    chk_busy_len: assert property ($fell(busy) |-> lenQ == BUSY_CYCLES)
        else $error("busy length");
    chk_busy_cause: assert property ($rose(busy) |-> opStart || $past(opStart))
        else $error("busy uncaused");
    chk_latch_end: assert property ($fell(busy) |-> !wrLatch)
        else $error("latch kept");
    chk_latch_busy: assert property (busy |-> wrLatch)
        else $error("latch lost");
    chk_latch_set: assert property ($rose(wrLatch) |-> !busy && csN)
        else $error("latch set in frame");
    chk_reject_quiet: assert property (opReject |-> !busy && !opStart)
        else $error("reject started op");
endmodule // sfh_monitor
bind sfh_top sfh_monitor #(.BUSY_CYCLES(BUSY_CYCLES)) mon (.clock(clock), .rst(rst),
    .csN(csN), .sck(sck), .si(si), .holdN(holdN), .wpN(wpN), .so(so), .soOe(soOe),
    .busy(busy), .wrLatch(wrLatch), .opStart(opStart), .opReject(opReject));
`default_nettype wire

// >>> tb/sfh_host.sv
`timescale 1ns/10ps
`default_nettype none
module sfh_host (
    input wire logic clock,
    input wire logic so,
    output logic csN = 1'b1,
    output logic sck = 1'b0,
    output logic si = 1'b0,
    output logic holdN = 1'b1,
    output logic wpN = 1'b1
);
    // one sck phase, 400 ns
    task automatic half();
        repeat (4) @(negedge clock);
    endtask
    // p: bit to pause before (-1 none); ab: deselect while paused
    task automatic xfer(input logic [39:0] d, input int n, input int p, input bit ab,
        output logic [7:0] rd);
        csN = 1'b0;
        for (int i = 8 * n - 1; i >= 0; i--)
        begin
            si = d[i];
            half();
            if (i == p)
            begin
                holdN = 1'b0;
                // junk on sck and si, must be ignored
                repeat (4)
                begin
                    half();
                    sck = ~sck;
                    si = ~si;
                end
                half();
                if (ab)
                begin
                    csN = 1'b1;
                    half();
                    holdN = 1'b1;
                    half();
                    return;
                end
                holdN = 1'b1;
                si = d[i];
                half();
            end
            sck = 1'b1;
            half();
            rd = {rd[6:0], so};
            sck = 1'b0;
        end
        half();
        csN = 1'b1;
        si = ~si;
        repeat (2) half();
    endtask
endmodule // sfh_host
`default_nettype wire

// >>> tb/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic csN, sck, si, holdN, wpN, so, soOe, busy, wrLatch, opStart, opReject;
    logic [7:0] v;
    int errTotal = 0;
    int testsRun = 0;
    int starts = 0;
    int rejects = 0;
    int s;
    // status, byte count, accepted, frame
    localparam logic [51:0] ROWS [12] = '{
        {8'h04, 3'd4, 1'b1, 40'h2006ffff}, {8'h04, 3'd4, 1'b0, 40'hd7070000},
        {8'h08, 3'd4, 1'b0, 40'hd8060000}, {8'h0c, 3'd5, 1'b1, 40'h0203ffff5a},
        {8'h0c, 3'd5, 1'b0, 40'h020400005a}, {8'h24, 3'd4, 1'b0, 40'h2000ffff},
        {8'h28, 3'd4, 1'b1, 40'h20020000}, {8'h2c, 3'd4, 1'b0, 40'h2003ffff},
        {8'h10, 3'd4, 1'b0, 40'h20000000}, {8'h3c, 3'd4, 1'b0, 40'h2007ffff},
        {8'h04, 3'd1, 1'b0, 40'h60}, {8'h00, 3'd1, 1'b1, 40'hc7}};
    always #50 clock = ~clock;
    sfh_top #(.BUSY_CYCLES(300)) dut (.clock(clock), .rst(rst), .csN(csN), .sck(sck),
        .si(si), .holdN(holdN), .wpN(wpN), .so(so), .soOe(soOe), .busy(busy),
        .wrLatch(wrLatch), .opStart(opStart), .opReject(opReject));
    sfh_host host (.clock(clock), .so(so), .csN(csN), .sck(sck), .si(si),
        .holdN(holdN), .wpN(wpN));
    always @(posedge clock)
    begin
        starts <= starts + int'(opStart);
        rejects <= rejects + int'(opReject);
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        testsRun++;
        if (seen !== exp)
        begin
            errTotal++;
            $display("wrong value at %0t: %h vs %h", $time, seen, exp);
        end
    endtask
    task automatic printVerdict();
        $display("checks %0d mismatches %0d", testsRun, errTotal);
        if (errTotal == 0 && testsRun > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic send(input logic [39:0] d, input int n);
        host.xfer(d, n, -1, 1'b0, v);
    endtask
    task automatic waitIdle();
        for (int i = 0; i < 400 && busy !== 1'b0; i++)
            @(negedge clock);
        check(8'(busy), 8'h00);
    endtask
    task automatic status_write_cmd(input logic [7:0] x);
        send(40'h06, 1);
        send(40'({8'h01, x}), 2);
        waitIdle();
    endtask
    task automatic testReset();
        check(8'(busy), 8'h00);
        check(8'(wrLatch), 8'h00);
        send(40'h0500, 2);
        check(v, 8'h00);
        $display("reset test done");
    endtask
    task automatic testLatch();
        send(40'h06, 1);
        check(8'(wrLatch), 8'h01);
        send(40'h0500, 2);
        check(v, 8'h02);
        send(40'h04, 1);
        check(8'(wrLatch), 8'h00);
        s = rejects;
        send(40'h010c, 2);
        send(40'h20000000, 4);
        check(8'(rejects - s), 8'h02);
        $display("latch test done");
    endtask
    task automatic testStatus();
        send(40'h06, 1);
        s = starts;
        send(40'h01ff, 2);
        check(8'(starts - s), 8'h01);
        send(40'h0500, 2);
        check(v, 8'hbf);
        waitIdle();
        send(40'h0500, 2);
        check(v, 8'hbc);
        check(8'(wrLatch), 8'h00);
        host.wpN = 1'b0;
        send(40'h06, 1);
        s = rejects;
        send(40'h0100, 2);
        check(8'(rejects - s), 8'h01);
        send(40'h0500, 2);
        check(v, 8'hbe);
        host.wpN = 1'b1;
        status_write_cmd(8'h00);
        send(40'h0500, 2);
        check(v, 8'h00);
        $display("status test done");
    endtask
    task automatic testRegions();
        foreach (ROWS[k])
        begin
            status_write_cmd(ROWS[k][51:44]);
            send(40'h06, 1);
            s = starts;
            send(ROWS[k][39:0], int'(ROWS[k][43:41]));
            check(8'(starts - s), 8'(ROWS[k][40]));
            waitIdle();
            if (ROWS[k][40])
                check(8'(wrLatch), 8'h00);
        end
        $display("region test done");
    endtask
    task automatic testPause();
        host.xfer(40'h06, 1, 4, 1'b0, v);
        check(8'(wrLatch), 8'h01);
        host.xfer(40'h04, 1, 3, 1'b1, v);
        check(8'(wrLatch), 8'h01);
        host.xfer(40'h0500, 2, 5, 1'b0, v);
        check(v, 8'h02);
        send(40'h04, 1);
        check(8'(wrLatch), 8'h00);
        $display("pause test done");
    endtask
    initial
    begin
        repeat (20) @(negedge clock);
        rst = 1'b0;
        repeat (4) @(negedge clock);
        testReset();
        testLatch();
        testStatus();
        testRegions();
        testPause();
        printVerdict();
    end
    initial
    begin
        #4_000_000;
        errTotal++;
        printVerdict();
    end
endmodule // testbench
`default_nettype wire
